// >>> uafm_pkg.sv
// Package: register map, field positions, reset values and state types of the enhanced serial port
package uafm_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0]  IDX_POWER_CTRL  = 8'h87;
   localparam logic [7:0]  IDX_SERIAL_CTRL = 8'h98;
   localparam logic [7:0]  IDX_SERIAL_DATA = 8'h99;
   localparam logic [7:0]  IDX_SLAVE_ADDR  = 8'ha9;
   localparam logic [7:0]  IDX_SLAVE_MASK  = 8'haa;
   localparam logic [7:0]  IDX_T2_CTRL     = 8'hc8;
   localparam logic [7:0]  IDX_T2_RELOAD   = 8'hcb;
   localparam logic [7:0]  IDX_T2_COUNT    = 8'hcc;
   localparam logic [7:0]  IDX_INT_STATUS  = 8'hf0;
   localparam logic [7:0]  IDX_INT_MASK    = 8'hf1;
   localparam int          ADDR_W          = 12;

   // ----------------------------------------------------------------
   // Reset values, field positions and timing
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [15:0] RST_WORD        = 16'h0000;
   localparam logic [15:0] T2_TOP          = 16'hffff;
   localparam logic [3:0]  SAMPLE_MID      = 4'h7;
   localparam logic [3:0]  SAMPLE_LAST     = 4'hf;
   localparam logic [3:0]  DATA_BITS       = 4'h8;
   localparam int          EV_RX_DONE      = 0;
   localparam int          EV_TX_DONE      = 1;
   localparam int          EV_FRAME_ERR    = 2;
   localparam int          EV_T2_OVF       = 3;
   localparam int          EV_T2_EXT       = 4;
   localparam int          EV_W            = 5;

   // Serial modes {mode bit 0, mode bit 1}
   localparam logic [1:0]  MODE_SHIFT      = 2'h0;
   localparam logic [1:0]  MODE_ASYNC8     = 2'h1;
   localparam logic [1:0]  MODE_ASYNC9F    = 2'h2;

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = {2'h0, idx, 2'h0};
   endfunction

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      LN_IDLE  = 5'h01,
      LN_START = 5'h02,
      LN_DATA  = 5'h04,
      LN_NINTH = 5'h08,
      LN_STOP  = 5'h10
   } uafm_line_st_t;

   typedef struct packed {
      logic mode_bit0;
      logic mode_bit1;
      logic multiproc_enable;
      logic rx_enable;
      logic tx_ninth;
      logic rx_ninth;
      logic transmit_done_flag;
      logic receive_done_flag;
      logic framing_error_flag;
   } uafm_serial_ctrl_t;

   typedef struct packed {
      logic t2_overflow_flag;
      logic t2_ext_flag;
      logic rx_clock_select;
      logic tx_clock_select;
      logic ext_trigger_enable;
      logic t2_run;
      logic t2_counter_select;
      logic capture_reload_select;
   } uafm_t2_ctrl_t;

   typedef struct packed {
      uafm_serial_ctrl_t sc;
      logic              double_rate;
      logic              frame_error_select;
      uafm_t2_ctrl_t     t2c;
      logic [7:0]        slave_address;
      logic [7:0]        slave_address_mask;
      logic [7:0]        rx_data;
      logic [15:0]       t2_count;
      logic [15:0]       t2_reload;
      logic [EV_W-1:0]   int_stat;
      logic [EV_W-1:0]   int_mask;
      logic              irq;
      logic              trig_prev;
      logic              t2pin_prev;
      logic [1:0]        fix_div;
      logic              rx_half;
      logic              tx_half;
      uafm_line_st_t     rx_st;
      logic [3:0]        rx_cnt;
      logic [3:0]        rx_bits;
      logic [7:0]        rx_shift;
      logic              rx_bit9;
      uafm_line_st_t     tx_st;
      logic [3:0]        tx_cnt;
      logic [3:0]        tx_bits;
      logic [8:0]        tx_shift;
      logic              txd;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
   } uafm_state_t;

endpackage

// >>> uafm_core.sv
// Enhanced serial port: framing check, address recognition, baud source select, timer 2, APB slave
//
// What this block does
// - Framing check only modes 1-3, select set
// - Invalid stop bit sets framing error flag
// - Framing error sticky until software or reset
// - Framing check on: receive done at stop
// - Multiproc: receive done only on address match
// - Mode 1 multiproc: match plus valid stop
// - Multiproc enable ignored in mode 0
// - Given address: masked bits must equal
// - Broadcast: address OR mask, zeros ignored
// - Reset clears address and mask registers
// - Modes 1,3 rx clock timer1/timer2 select
// - Modes 1,3 tx clock timer1/timer2 select
// - Timer2 flag set only when not baud
// - Baud use forces timer2 auto-reload
// - Trigger falling edge acts only if enabled
// - Full duplex; independent baud rates in modes 1,3 only
// - Control bit 7 is flag or mode bit
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module uafm_core
   import uafm_pkg::*;
(
   // Clock and reset
   input  wire logic              CORE_CLK_I,
   input  wire logic              RESET_N_I,
   // APB slave
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   output logic [31:0]            PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   // Serial line and timer pins
   input  wire logic              RXD_I,
   output logic                   TXD_O,
   input  wire logic              T1_OVF_I,
   input  wire logic              T2_COUNT_I,
   input  wire logic              T2_EXT_TRIG_I,
   // Interrupt
   output logic                   IRQ_O
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Given or broadcast address hit; zero mask bits are don't-care in the given address, zero bits of address OR mask in broadcast
   function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] adr, input logic [7:0] msk);
      logic [7:0] bcast;
      bcast = adr | msk;
      addr_hit = (((rx ^ adr) & msk) == 8'h00)
               || (((rx ^ bcast) & bcast) == 8'h00);
   endfunction

   // Pick the baud source for one direction in modes 1 and 3
   function automatic logic baud_src(input logic use_t2, input logic t2_ovf, input logic t1_ovf);
      baud_src = use_t2 ? t2_ovf : t1_ovf;
   endfunction

   uafm_state_t s_reg;
   uafm_state_t s_next;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [1:0]      mode;
      logic            fe_en;
      logic            mp_on;
      logic            t2_tick;
      logic            t2_baud;
      logic            t2_ovf;
      logic            ext_ev;
      logic            src_rx;
      logic            src_tx;
      logic            fix_tick;
      logic            rx_tick;
      logic            tx_tick;
      logic            setup;
      logic            acc;
      logic            wr;
      logic [7:0]      idx;
      logic [7:0]      wb;
      logic            tx_go;
      logic            fin;
      logic            stop_known;
      logic            stop_bit;
      logic            accept;
      logic [EV_W-1:0] ev;
      logic [31:0]     rd;
      logic            hit;
      mode       = 2'h0;
      fe_en      = 1'b0;
      mp_on      = 1'b0;
      t2_tick    = 1'b0;
      t2_baud    = 1'b0;
      t2_ovf     = 1'b0;
      ext_ev     = 1'b0;
      src_rx     = 1'b0;
      src_tx     = 1'b0;
      fix_tick   = 1'b0;
      rx_tick    = 1'b0;
      tx_tick    = 1'b0;
      tx_go      = 1'b0;
      fin        = 1'b0;
      stop_known = 1'b0;
      stop_bit   = 1'b0;
      accept     = 1'b0;
      ev         = '0;
      rd         = 32'h0000_0000;
      hit        = 1'b1;
      s_next     = s_reg;

      mode    = {s_reg.sc.mode_bit0, s_reg.sc.mode_bit1};
      fe_en   = s_reg.frame_error_select && (mode != MODE_SHIFT);
      mp_on   = s_reg.sc.multiproc_enable && (mode != MODE_SHIFT);
      setup   = PSEL_I && !PENABLE_I;
      acc     = PSEL_I && PENABLE_I && s_reg.pready;
      wr      = acc && PWRITE_I;
      idx     = PADDR_I[9:2];
      wb      = PWDATA_I[7:0];

      // Software writes; hardware sets further down win over these clears
      if (wr)
      begin
         case (idx)
            IDX_SERIAL_CTRL:
            begin
               if (s_reg.frame_error_select)
                  s_next.sc.framing_error_flag = wb[7];
               else
                  s_next.sc.mode_bit0 = wb[7];
               {s_next.sc.mode_bit1, s_next.sc.multiproc_enable, s_next.sc.rx_enable,
                s_next.sc.tx_ninth, s_next.sc.rx_ninth, s_next.sc.transmit_done_flag,
                s_next.sc.receive_done_flag} = wb[6:0];
            end
            IDX_SERIAL_DATA: tx_go = 1'b1;
            IDX_POWER_CTRL:  {s_next.double_rate, s_next.frame_error_select} = wb[7:6];
            IDX_SLAVE_ADDR:  s_next.slave_address = wb;
            IDX_SLAVE_MASK:  s_next.slave_address_mask = wb;
            IDX_T2_CTRL:     s_next.t2c = wb;
            IDX_T2_RELOAD:   s_next.t2_reload = PWDATA_I[15:0];
            IDX_T2_COUNT:    s_next.t2_count = PWDATA_I[15:0];
            IDX_INT_MASK:    s_next.int_mask = PWDATA_I[EV_W-1:0];
            default:         s_next.t2_reload = s_next.t2_reload;
         endcase
      end

      // Timer 2: counting, overflow, reload and external trigger
      t2_baud = s_reg.t2c.rx_clock_select || s_reg.t2c.tx_clock_select;
      t2_tick = s_reg.t2c.t2_run
             && (!s_reg.t2c.t2_counter_select || (s_reg.t2pin_prev && !T2_COUNT_I));
      t2_ovf  = t2_tick && (s_reg.t2_count == T2_TOP);
      if (t2_ovf)
         s_next.t2_count = (t2_baud || !s_reg.t2c.capture_reload_select)
                         ? s_reg.t2_reload : RST_WORD;
      else if (t2_tick)
         s_next.t2_count = s_reg.t2_count + 16'h0001;
      ext_ev = s_reg.trig_prev && !T2_EXT_TRIG_I
            && s_reg.t2c.ext_trigger_enable && !t2_baud;
      if (ext_ev)
      begin
         if (s_reg.t2c.capture_reload_select)
            s_next.t2_reload = s_reg.t2_count;
         else
            s_next.t2_count = s_reg.t2_reload;
         s_next.t2c.t2_ext_flag = 1'b1;
      end
      if (t2_ovf && !t2_baud)
         s_next.t2c.t2_overflow_flag = 1'b1;
      s_next.trig_prev  = T2_EXT_TRIG_I;
      s_next.t2pin_prev = T2_COUNT_I;

      // Sample ticks, 16 per bit; in modes 1 and 3 each direction keeps its own source
      s_next.fix_div = s_reg.fix_div + 2'h1;
      fix_tick = s_reg.double_rate ? s_reg.fix_div[0] : (&s_reg.fix_div);
      src_rx = baud_src(s_reg.t2c.rx_clock_select, t2_ovf, T1_OVF_I);
      src_tx = baud_src(s_reg.t2c.tx_clock_select, t2_ovf, T1_OVF_I);
      if (src_rx)
         s_next.rx_half = !s_reg.rx_half;
      if (src_tx)
         s_next.tx_half = !s_reg.tx_half;
      case (mode)
         MODE_SHIFT:
         begin
            rx_tick = 1'b1;
            tx_tick = 1'b1;
         end
         MODE_ASYNC9F:
         begin
            rx_tick = fix_tick;
            tx_tick = fix_tick;
         end
         default:
         begin
            rx_tick = src_rx && (s_reg.double_rate || s_reg.rx_half);
            tx_tick = src_tx && (s_reg.double_rate || s_reg.tx_half);
         end
      endcase

      // Receiver; runs alongside the transmitter
      if (rx_tick)
      begin
         s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
         case (s_reg.rx_st)
            LN_IDLE:
            begin
               s_next.rx_cnt = 4'h0;
               if (s_reg.sc.rx_enable && !RXD_I)
                  s_next.rx_st = (mode == MODE_SHIFT) ? LN_DATA : LN_START;
               s_next.rx_bits = 4'h0;
            end
            LN_START:
            begin
               // A start bit that is high again at mid-bit was a glitch
               if (s_reg.rx_cnt == SAMPLE_MID && RXD_I)
                  s_next.rx_st = LN_IDLE;
               else if (s_reg.rx_cnt == SAMPLE_LAST)
                  s_next.rx_st = LN_DATA;
            end
            LN_DATA:
            begin
               if (s_reg.rx_cnt == SAMPLE_MID)
               begin
                  s_next.rx_shift = {RXD_I, s_reg.rx_shift[7:1]};
                  s_next.rx_bits  = s_reg.rx_bits + 4'h1;
               end
               if (s_reg.rx_cnt == SAMPLE_LAST && s_reg.rx_bits == DATA_BITS)
               begin
                  if (mode == MODE_SHIFT)
                  begin
                     fin = 1'b1;
                     s_next.rx_st = LN_IDLE;
                  end
                  else
                     s_next.rx_st = (mode == MODE_ASYNC8) ? LN_STOP : LN_NINTH;
               end
            end
            LN_NINTH:
            begin
               if (s_reg.rx_cnt == SAMPLE_MID)
               begin
                  s_next.rx_bit9 = RXD_I;
                  // Without framing check the frame ends at its last data bit
                  if (!fe_en)
                  begin
                     fin = 1'b1;
                     s_next.rx_st = LN_IDLE;
                  end
               end
               else if (s_reg.rx_cnt == SAMPLE_LAST)
                  s_next.rx_st = LN_STOP;
            end
            LN_STOP:
            begin
               if (s_reg.rx_cnt == SAMPLE_MID)
               begin
                  fin = 1'b1;
                  stop_known = 1'b1;
                  stop_bit = RXD_I;
                  s_next.rx_st = LN_IDLE;
               end
            end
            default: s_next.rx_st = LN_IDLE;
         endcase
      end

      // Frame completion: framing check, address filter, receive done
      if (fin)
      begin
         hit = addr_hit(s_reg.rx_shift, s_reg.slave_address, s_reg.slave_address_mask);
         if (fe_en && stop_known && !stop_bit)
         begin
            s_next.sc.framing_error_flag = 1'b1;
            ev[EV_FRAME_ERR] = 1'b1;
         end
         case (mode)
            MODE_SHIFT:  accept = 1'b1;
            MODE_ASYNC8: accept = !mp_on || (stop_bit && hit);
            default:     accept = !mp_on || (s_reg.rx_bit9 && hit);
         endcase
         // A frame arriving while receive done is still set is lost
         if (accept && !s_reg.sc.receive_done_flag)
         begin
            s_next.rx_data = s_reg.rx_shift;
            if (mode == MODE_ASYNC8)
               s_next.sc.rx_ninth = stop_bit;
            else if (mode != MODE_SHIFT)
               s_next.sc.rx_ninth = s_reg.rx_bit9;
            s_next.sc.receive_done_flag = 1'b1;
            ev[EV_RX_DONE] = 1'b1;
         end
      end

      // Transmitter; a data write while busy is ignored
      if (tx_go && s_reg.tx_st == LN_IDLE)
      begin
         s_next.tx_shift = {s_reg.sc.tx_ninth, wb};
         s_next.tx_cnt   = 4'h0;
         s_next.tx_bits  = 4'h0;
         s_next.tx_st    = (mode == MODE_SHIFT) ? LN_DATA : LN_START;
         s_next.txd      = (mode == MODE_SHIFT) ? wb[0] : 1'b0;
      end
      else if (tx_tick && s_reg.tx_st != LN_IDLE)
      begin
         s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
         if (s_reg.tx_cnt == SAMPLE_LAST)
         begin
            case (s_reg.tx_st)
               LN_START:
               begin
                  s_next.tx_st = LN_DATA;
                  s_next.txd   = s_reg.tx_shift[0];
               end
               LN_DATA:
               begin
                  s_next.tx_bits  = s_reg.tx_bits + 4'h1;
                  s_next.tx_shift = {1'b0, s_reg.tx_shift[8:1]};
                  s_next.txd      = s_reg.tx_shift[1];
                  if (s_reg.tx_bits == DATA_BITS - 4'h1)
                  begin
                     if (mode == MODE_SHIFT)
                     begin
                        s_next.tx_st = LN_IDLE;
                        s_next.txd   = 1'b1;
                        s_next.sc.transmit_done_flag = 1'b1;
                        ev[EV_TX_DONE] = 1'b1;
                     end
                     else if (mode == MODE_ASYNC8)
                     begin
                        s_next.tx_st = LN_STOP;
                        s_next.txd   = 1'b1;
                        s_next.sc.transmit_done_flag = 1'b1;
                        ev[EV_TX_DONE] = 1'b1;
                     end
                     else
                        s_next.tx_st = LN_NINTH;
                  end
               end
               LN_NINTH:
               begin
                  s_next.tx_st = LN_STOP;
                  s_next.txd   = 1'b1;
                  s_next.sc.transmit_done_flag = 1'b1;
                  ev[EV_TX_DONE] = 1'b1;
               end
               default:
               begin
                  s_next.tx_st = LN_IDLE;
                  s_next.txd   = 1'b1;
               end
            endcase
         end
      end

      // Sticky interrupt status: read clears, a new event in the same cycle wins
      ev[EV_T2_OVF] = t2_ovf && !t2_baud;
      ev[EV_T2_EXT] = ext_ev;
      if (acc && !PWRITE_I && idx == IDX_INT_STATUS)
         s_next.int_stat = '0;
      s_next.int_stat = s_next.int_stat | ev;
      s_next.irq = |(s_next.int_stat & s_next.int_mask);

      // APB read data captured in setup; ready raised for the access cycle
      hit = 1'b1;                                                  // Frame filter above reuses this variable
      case (idx)
         IDX_SERIAL_CTRL:
            rd[7:0] = {s_reg.frame_error_select ? s_reg.sc.framing_error_flag : s_reg.sc.mode_bit0,
                       s_reg.sc.mode_bit1, s_reg.sc.multiproc_enable, s_reg.sc.rx_enable,
                       s_reg.sc.tx_ninth, s_reg.sc.rx_ninth, s_reg.sc.transmit_done_flag,
                       s_reg.sc.receive_done_flag};
         IDX_SERIAL_DATA: rd[7:0]      = s_reg.rx_data;
         IDX_POWER_CTRL:  rd[7:6]      = {s_reg.double_rate, s_reg.frame_error_select};
         IDX_SLAVE_ADDR:  rd[7:0]      = s_reg.slave_address;
         IDX_SLAVE_MASK:  rd[7:0]      = s_reg.slave_address_mask;
         IDX_T2_CTRL:     rd[7:0]      = s_reg.t2c;
         IDX_T2_RELOAD:   rd[15:0]     = s_reg.t2_reload;
         IDX_T2_COUNT:    rd[15:0]     = s_reg.t2_count;
         IDX_INT_STATUS:  rd[EV_W-1:0] = s_reg.int_stat;
         IDX_INT_MASK:    rd[EV_W-1:0] = s_reg.int_mask;
         default:         hit          = 1'b0;
      endcase
      if (PADDR_I[ADDR_W-1:10] != 2'h0 || PADDR_I[1:0] != 2'h0)
         hit = 1'b0;
      // Error stands only beside ready; read data holds until the next setup
      s_next.pready  = setup;
      s_next.pslverr = setup && !hit;
      if (setup)
         s_next.prdata = hit ? rd : 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         s_reg                    <= '0;
         s_reg.slave_address      <= RST_BYTE;
         s_reg.slave_address_mask <= RST_BYTE;
         s_reg.rx_st              <= LN_IDLE;
         s_reg.tx_st              <= LN_IDLE;
         s_reg.txd                <= 1'b1;
         s_reg.trig_prev          <= 1'b1;
         s_reg.t2pin_prev         <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   // Outputs straight from the state register
   assign PRDATA_O  = s_reg.prdata;
   assign PREADY_O  = s_reg.pready;
   assign PSLVERR_O = s_reg.pslverr;
   assign TXD_O     = s_reg.txd;
   assign IRQ_O     = s_reg.irq;

endmodule
`default_nettype wire

// >>> uafm_checker.sv
// Bus and reset checks on the enhanced serial port top
`timescale 1ns/1ps
`default_nettype none
module uafm_checker
   import uafm_pkg::*;
(
   // Clock, reset and bus
   input wire logic              CORE_CLK_I,
   input wire logic              RESET_N_I,
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic              PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0]       PRDATA_O,
   input wire logic              PREADY_O,
   input wire logic              PSLVERR_O,
   // Line and interrupt
   input wire logic              TXD_O,
   input wire logic              IRQ_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // -----
   // Bus phases
   // -----
   sequence setup_s;
      PSEL_I && !PENABLE_I;
   endsequence
   sequence done_s;
      PSEL_I && PENABLE_I && PREADY_O;
   endsequence
   ready_after_setup_a: assert property (setup_s |=> done_s) else $error("no ready after setup");
   ready_one_cycle_a: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
   ready_cause_a: assert property (PREADY_O |-> $past(PSEL_I && !PENABLE_I)) else $error("stray ready");
   slverr_ready_a: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
   unmapped_err_a: assert property (setup_s and PADDR_I == '0 |=> PSLVERR_O) else $error("no error");
   mapped_ok_a: assert property (setup_s and PADDR_I == 12'h2a4 |=> !PSLVERR_O) else $error("bad error");
   err_data_a: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0) else $error("error data");
   upper_zero_a: assert property (PREADY_O |-> PRDATA_O[31:16] == 16'h0) else $error("upper bits set");
   // Outputs must still show reset values at the first edge after release
   reset_idle_a: assert property ($rose(RESET_N_I) |-> TXD_O && !IRQ_O && !PREADY_O) else $error("not idle");
endmodule
bind uafm_core uafm_checker chk_u (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TXD_O(TXD_O), .IRQ_O(IRQ_O));
`default_nettype wire

// >>> uafm_peer.sv
// Remote serial node that sends asynchronous frames to the port
`timescale 1ns/1ps
`default_nettype none
module uafm_peer #(
   parameter int BIT_CLKS = 32
)
(
   // Clock and line
   input  wire logic clk_i,
   output logic      rxd_o
);
   // Line idles high between frames
   initial rxd_o = 1'b1;
   // Start, eight data bits LSB first, then stop (the ninth bit in mode 1)
   task automatic send(input logic [7:0] data, input logic stop);
      logic [9:0] frame;
      begin
         frame = {stop, data, 1'b0};
         for (int k = 0; k < 10; k++)
         begin
            @(posedge clk_i);
            rxd_o <= frame[k];
            repeat (BIT_CLKS - 1) @(posedge clk_i);
         end
         @(posedge clk_i);
         rxd_o <= 1'b1;
      end
   endtask
endmodule
`default_nettype wire

// >>> uart_frame_check_addr_match_bench.sv
// Self-checking bench for the enhanced serial port
`timescale 1ns/1ps
`default_nettype none
module uart_frame_check_addr_match_bench;
   import uafm_pkg::*;
   typedef struct packed {logic [7:0] b; logic stop; logic done;} uafm_row_t;
   logic              clk, rst_n, psel, penable, pwrite, t1_ovf, rxd, txd, pready, pslverr, irq, err, t2_ext_trigger_pin;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   int                error_cnt, checked, i, n;
   // Address 56h, mask fch: given 0101 01xx, broadcast 1111 111x
   uafm_row_t         rows [5] = '{
      '{8'h57, 1'b1, 1'b1},
      '{8'h46, 1'b1, 1'b0},
      '{8'hff, 1'b1, 1'b1},
      '{8'hfe, 1'b1, 1'b1},
      '{8'h57, 1'b0, 1'b0}};
   uafm_core dut_u (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .RXD_I(rxd), .TXD_O(txd), .T1_OVF_I(t1_ovf), .T2_COUNT_I(1'b1),
      .T2_EXT_TRIG_I(t2_ext_trigger_pin), .IRQ_O(irq));
   uafm_peer peer_u (.clk_i(clk), .rxd_o(rxd));
   // Clock; timer 1 overflows every second cycle, so one bit lasts 32 cycles at double rate
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) t1_ovf <= ~t1_ovf;
   task automatic finish_test;
      begin
         $display("checked=%0d error_cnt=%0d", checked, error_cnt);
         if (error_cnt == 0 && checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      begin
         checked++;
         if (got !== exp)
         begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // One bus transfer; the wait for ready is bounded
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= {2'h0, idx, 2'h0};
         pwdata <= wd;
         @(posedge clk);
         penable <= 1'b1;
         n = 0;
         do
         begin
            @(posedge clk);
            n++;
         end
         while (pready !== 1'b1 && n < 20);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (n >= 20)
         begin
            error_cnt++;
            finish_test;
         end
      end
   endtask
   task automatic do_reset;
      begin
         rst_n <= 1'b0;
         repeat (6) @(posedge clk);
         rst_n <= 1'b1;
      end
   endtask
   // -----
   // Main sequence
   // -----
   initial
   begin
      {rst_n, psel, penable, pwrite, t1_ovf} = '0;
      t2_ext_trigger_pin = 1'b1;
      paddr = '0;
      pwdata = '0;
      do_reset;
      apb(1'b0, IDX_SLAVE_ADDR, 32'h0);
      cmp(rd, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      cmp({31'h0, err}, 32'h1);
      apb(1'b1, IDX_SLAVE_ADDR, 32'h56);
      apb(1'b1, IDX_SLAVE_MASK, 32'hfc);
      apb(1'b0, IDX_SLAVE_MASK, 32'h0);
      cmp(rd, 32'hfc);
      apb(1'b1, IDX_POWER_CTRL, 32'h80);
      apb(1'b1, IDX_SERIAL_CTRL, 32'h70);
      for (i = 0; i < 5; i++)
      begin
         peer_u.send(rows[i].b, rows[i].stop);
         repeat (8) @(posedge clk);
         apb(1'b0, IDX_SERIAL_CTRL, 32'h0);
         cmp({31'h0, rd[0]}, {31'h0, rows[i].done});
         apb(1'b1, IDX_SERIAL_CTRL, 32'h70);
      end
      // A low stop can look like a new start, so let any false frame die before resetting
      repeat (400) @(posedge clk);
      do_reset;
      apb(1'b0, IDX_SLAVE_MASK, 32'h0);
      cmp(rd, 32'h0);
      // Framing check with a sticky flag
      apb(1'b1, IDX_SERIAL_CTRL, 32'h50);
      apb(1'b1, IDX_POWER_CTRL, 32'hc0);
      apb(1'b1, IDX_INT_MASK, 32'h04);
      peer_u.send(8'ha5, 1'b0);
      repeat (8) @(posedge clk);
      apb(1'b0, IDX_SERIAL_CTRL, 32'h0);
      cmp({31'h0, rd[7]}, 32'h1);
      repeat (400) @(posedge clk);
      peer_u.send(8'h3c, 1'b1);
      repeat (8) @(posedge clk);
      apb(1'b0, IDX_SERIAL_CTRL, 32'h0);
      cmp({31'h0, rd[7]}, 32'h1);
      cmp({31'h0, irq}, 32'h1);
      apb(1'b1, IDX_POWER_CTRL, 32'h80);
      apb(1'b0, IDX_SERIAL_CTRL, 32'h0);
      cmp({31'h0, rd[7]}, 32'h0);
      apb(1'b0, IDX_INT_STATUS, 32'h0);
      cmp({31'h0, rd[2]}, 32'h1);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      // Timer 2 flag: set on overflow only while no baud select; count is loaded while stopped
      apb(1'b1, IDX_T2_COUNT, 32'hfffe);
      apb(1'b1, IDX_T2_CTRL, 32'h04);
      repeat (4) @(posedge clk);
      apb(1'b0, IDX_T2_CTRL, 32'h0);
      cmp(rd, 32'h84);
      apb(1'b1, IDX_T2_CTRL, 32'h30);
      apb(1'b1, IDX_T2_COUNT, 32'hfffe);
      apb(1'b1, IDX_T2_CTRL, 32'h34);
      repeat (4) @(posedge clk);
      apb(1'b0, IDX_T2_CTRL, 32'h0);
      cmp(rd, 32'h34);
      // Trigger falling edge: ignored while timer 2 clocks the port, acts otherwise
      apb(1'b1, IDX_T2_CTRL, 32'h38);
      t2_ext_trigger_pin <= 1'b0;
      repeat (2) @(posedge clk);
      t2_ext_trigger_pin <= 1'b1;
      apb(1'b0, IDX_T2_CTRL, 32'h0);
      cmp(rd, 32'h38);
      apb(1'b1, IDX_T2_CTRL, 32'h08);
      t2_ext_trigger_pin <= 1'b0;
      repeat (2) @(posedge clk);
      t2_ext_trigger_pin <= 1'b1;
      apb(1'b0, IDX_T2_CTRL, 32'h0);
      cmp(rd, 32'h48);
      // A data write starts a frame: the line drops to the start bit one cycle later
      apb(1'b1, IDX_SERIAL_DATA, 32'h55);
      @(posedge clk);
      cmp({31'h0, txd}, 32'h0);
      finish_test;
   end
endmodule
`default_nettype wire
